// ---- common/fmsd_map.vh ----
/*
 * constants for the fixed memory select decoder: address field positions,
 * bank limits, alarm ranges and reset values.
 * assumes it is included by bare name from design files only.
 */
`ifndef FMSD_MAP_VH
`define FMSD_MAP_VH

// address register field positions (bit 1 of the word is index 0)
`define FMSD_ADDR_W        12
`define FMSD_WORD_HI       9
`define FMSD_SET_BIT       7
`define FMSD_STRAND_LO     8
`define FMSD_STRAND_HI     9
`define FMSD_PAR_HI        8
`define FMSD_INH_HI        6
`define FMSD_QUAD_HI       11
`define FMSD_QUAD_LO       10

// address quadrant codes (bits 12 and 11)
`define FMSD_QUAD_ERASE    2'h0
`define FMSD_QUAD_BANK1    2'h1
`define FMSD_QUAD_BANK2    2'h2
`define FMSD_QUAD_SWITCH   2'h3

// bank numbers, five bits, octal values given in hex
`define FMSD_BANK_W        5
`define FMSD_BANK_ONE      5'h01
`define FMSD_BANK_TWO      5'h02
`define FMSD_BANK_THREE    5'h03
`define FMSD_LOW_LAST      5'h0c
`define FMSD_HIGH_FIRST    5'h11
`define FMSD_HIGH_LAST     5'h1c
`define FMSD_HIGH_SHIFT    5'h05

// pseudo address layout for manual access
`define FMSD_PSEUDO_W      15
`define FMSD_PSEUDO_BANK_LO 10

// reset values
`define FMSD_ALARM_N_RST   1'h1

`endif

// ---- design/fmsd_decoder.v ----
/*
 * fixed memory select decoder: bank, rope, set, strand, inhibit and
 * parity inhibit decode for the core rope fixed memory, plus bank alarms.
 * assumes bank and address inputs, strobes and manual inputs come from
 * registers on mclk_in; only the supply clamp is asynchronous.
 */
//
// Behaviour
// - banked fixed memory: bank from five bank bits, word from address bits 10..1
// - bank bits, complements and address bits 12,11 pick one of six rope selects
// - one of 24 banks of 1024 words, active only under bank-select strobe
// - bank decode also yields set enable and a pair of strand enables
// - all rope selects suppressed while the supply clamp is high
// - invalid bank raises alarm one or two, combined into one alarm line
// - address bit 8 and set enable pick one of four set lines under set strobe
// - seven low address bits and complements inverted onto inhibit lines
// - address bit 9 gated with nine-bit parity gives parity inhibit and complement
// - parity true when address bits 9..1 hold an even number of ones
// - address bits 9,10 and strand enables pick one of eight strand gates
// - 0200 blocks alternate sets; odd banks use C/D, even banks A/B
// - strand advances every 0400; strand groups paired across banks as mapped
// - pseudo octal addresses act as real addresses under manual access
`timescale 1ns/1ps
`default_nettype none
`include "fmsd_map.vh"

module fmsd_decoder #(
    parameter ROPES   = 6,
    parameter STRANDS = 8,
    parameter INH_W   = 7
) (
    // clock and reset
    input  wire                          mclk_in,
    input  wire                          rst_in,
    // address sources
    input  wire [`FMSD_BANK_W-1:0]       bank_number_register_in,
    input  wire [`FMSD_ADDR_W-1:0]       addr_in,
    input  wire                          manual_access_in,
    input  wire [`FMSD_PSEUDO_W-1:0]     manual_pseudo_addr_in,
    // timing strobes
    input  wire                          bank_select_strobe_in,
    input  wire                          set_strobe_in,
    input  wire                          inhibit_strobe_in,
    // supply monitor, asynchronous
    input  wire                          supply_fault_clamp_in,
    // rope, set and strand drive
    output reg  [ROPES-1:0]              rope_select_out,
    output reg                           set_enable_out,
    output reg                           strand_enable_a_out,
    output reg                           strand_enable_b_out,
    output reg  [3:0]                    set_line_out,
    output reg  [STRANDS-1:0]            strand_gate_out,
    // inhibit drive
    output reg  [INH_W-1:0]              inhibit_true_out,
    output reg  [INH_W-1:0]              inhibit_comp_out,
    output reg                           parity_inhibit_out,
    output reg                           parity_inhibit_n_out,
    // alarms and status
    output reg                           bank_alarm_one_out,
    output reg                           bank_alarm_two_out,
    output reg                           combined_bank_alarm_n_out,
    output reg  [`FMSD_BANK_W-1:0]       fixed_bank_out
);

////////////////////////////////////////////////////////////////////////////////
// clamp synchroniser

reg clamp_meta_r;
reg clamp_sync_r;

// analogue monitor is unrelated to mclk_in, so two stages first
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        clamp_meta_r <= 1'h1;                  // clamp held until proven good
        clamp_sync_r <= 1'h1;
    end else begin
        clamp_meta_r <= supply_fault_clamp_in;
        clamp_sync_r <= clamp_meta_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// address source selection

reg  [`FMSD_BANK_W-1:0] bank_sel;
reg  [9:0]              word_sel;
reg                     fixed_sel;

// manual pseudo address carries the bank in its top five bits
always @* begin
    word_sel  = addr_in[`FMSD_WORD_HI:0];
    fixed_sel = 1'h1;
    bank_sel  = bank_number_register_in;
    if (manual_access_in) begin
        bank_sel = manual_pseudo_addr_in[`FMSD_PSEUDO_W-1:`FMSD_PSEUDO_BANK_LO];
        word_sel = manual_pseudo_addr_in[`FMSD_WORD_HI:0];
    end else begin
        case (addr_in[`FMSD_QUAD_HI:`FMSD_QUAD_LO])
            `FMSD_QUAD_ERASE: begin
                fixed_sel = 1'h0;              // erasable path, no fixed drive
            end
            `FMSD_QUAD_BANK1: begin
                bank_sel = `FMSD_BANK_ONE;
            end
            `FMSD_QUAD_BANK2: begin
                bank_sel = `FMSD_BANK_TWO;
            end
            `FMSD_QUAD_SWITCH: begin
                // bank register values below three all fold onto bank 03
                if (bank_number_register_in < `FMSD_BANK_THREE) begin
                    bank_sel = `FMSD_BANK_THREE;
                end
            end
            default: begin
                fixed_sel = 1'h0;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// bank decode

wire       low_valid  = (bank_sel >= `FMSD_BANK_ONE) && (bank_sel <= `FMSD_LOW_LAST);
wire       high_valid = (bank_sel >= `FMSD_HIGH_FIRST) && (bank_sel <= `FMSD_HIGH_LAST);
wire       bank_valid = low_valid || high_valid;
// gap banks 15..20 octal raise alarm one, zero and 35..37 alarm two
wire       alarm_one  = fixed_sel && (bank_sel > `FMSD_LOW_LAST) &&
                        (bank_sel < `FMSD_HIGH_FIRST);
wire       alarm_two  = fixed_sel && !bank_valid && !alarm_one;
wire       drive_ok   = fixed_sel && bank_valid;

// dense bank ordinal 0..23: four banks per rope
wire [4:0] bank_ord   = low_valid ? (bank_sel - `FMSD_BANK_ONE)
                                  : (bank_sel - `FMSD_HIGH_SHIFT);
wire [2:0] rope_idx   = bank_ord[4:2];
// first and last bank of a rope share one strand group, middle two the other
wire       strand_grp = bank_ord[1] ^ bank_ord[0];
wire       odd_bank   = bank_sel[0];
wire [2:0] strand_idx = {strand_grp, word_sel[`FMSD_STRAND_HI],
                         word_sel[`FMSD_STRAND_LO]};
wire [1:0] set_idx    = {odd_bank, word_sel[`FMSD_SET_BIT]};
wire       par_even   = ~^word_sel[`FMSD_PAR_HI:0];
wire       par_inh    = word_sel[`FMSD_PAR_HI] & par_even;

////////////////////////////////////////////////////////////////////////////////
// rope, strand and enable outputs

genvar gi;

// set and strand enables and the fixed bank follow the address every cycle, with no strobe gating
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        set_enable_out      <= 1'h0;
        strand_enable_a_out <= 1'h0;
        strand_enable_b_out <= 1'h0;
        fixed_bank_out      <= {`FMSD_BANK_W{1'h0}};
    end else begin
        set_enable_out      <= drive_ok && odd_bank;
        strand_enable_a_out <= drive_ok && !strand_grp;
        strand_enable_b_out <= drive_ok && strand_grp;
        fixed_bank_out      <= drive_ok ? bank_sel : {`FMSD_BANK_W{1'h0}};
    end
end

generate
    for (gi = 0; gi < ROPES; gi = gi + 1) begin : g_rope
        // clamp only blocks the rope selects; other decodes keep running
        always @(posedge mclk_in or posedge rst_in) begin
            if (rst_in) begin
                rope_select_out[gi] <= 1'h0;
            end else begin
                rope_select_out[gi] <= drive_ok && bank_select_strobe_in &&
                                       !clamp_sync_r &&
                                       (rope_idx == gi);
            end
        end
    end
    for (gi = 0; gi < STRANDS; gi = gi + 1) begin : g_strand
        always @(posedge mclk_in or posedge rst_in) begin
            if (rst_in) begin
                strand_gate_out[gi] <= 1'h0;
            end else begin
                strand_gate_out[gi] <= drive_ok && bank_select_strobe_in &&
                                       (strand_idx == gi);
            end
        end
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_set
        always @(posedge mclk_in or posedge rst_in) begin
            if (rst_in) begin
                set_line_out[gi] <= 1'h0;
            end else begin
                set_line_out[gi] <= drive_ok && set_strobe_in &&
                                    (set_idx == gi);
            end
        end
    end
    for (gi = 0; gi < INH_W; gi = gi + 1) begin : g_inh
        // each bit drives both lines of a complementary pair, the true line inverted
        always @(posedge mclk_in or posedge rst_in) begin
            if (rst_in) begin
                inhibit_true_out[gi] <= 1'h0;
                inhibit_comp_out[gi] <= 1'h0;
            end else begin
                inhibit_true_out[gi] <= drive_ok && inhibit_strobe_in &&
                                        !word_sel[gi];
                inhibit_comp_out[gi] <= drive_ok && inhibit_strobe_in &&
                                        word_sel[gi];
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// parity inhibit and alarms

// parity pair adds a second inhibit so every core sees at least two
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        parity_inhibit_out   <= 1'h0;
        parity_inhibit_n_out <= 1'h0;
    end else begin
        parity_inhibit_out   <= drive_ok && inhibit_strobe_in && par_inh;
        parity_inhibit_n_out <= drive_ok && inhibit_strobe_in && !par_inh;
    end
end

// alarms are levels following the address, not strobed
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        bank_alarm_one_out        <= 1'h0;
        bank_alarm_two_out        <= 1'h0;
        combined_bank_alarm_n_out <= `FMSD_ALARM_N_RST;
    end else begin
        bank_alarm_one_out        <= alarm_one;
        bank_alarm_two_out        <= alarm_two;
        combined_bank_alarm_n_out <= !(alarm_one || alarm_two);
    end
end

endmodule // fmsd_decoder

`default_nettype wire

// ---- dv/fmsd_decoder_properties.sv ----
/* port checker for fmsd_decoder: strobing, one-hot decodes, clamp, alarms.
   assumes one clock domain on mclk_in, async reset rst_in. */
`timescale 1ns/1ps
`default_nettype none
module fmsd_properties #(
    parameter ROPES   = 6,
    parameter STRANDS = 8,
    parameter INH_W   = 7
) (
    // clock, reset and causes
    input wire logic               mclk_in,
    input wire logic               rst_in,
    input wire logic [11:0]        addr_in,
    input wire logic               manual_access_in,
    input wire logic               bank_select_strobe_in,
    input wire logic               set_strobe_in,
    input wire logic               supply_fault_clamp_in,
    // decoder outputs
    input wire logic [ROPES-1:0]   rope_select_out,
    input wire logic               set_enable_out,
    input wire logic [3:0]         set_line_out,
    input wire logic [STRANDS-1:0] strand_gate_out,
    input wire logic [INH_W-1:0]   inhibit_comp_out,
    input wire logic               parity_inhibit_out,
    input wire logic               parity_inhibit_n_out,
    input wire logic               bank_alarm_one_out,
    input wire logic               bank_alarm_two_out,
    input wire logic               combined_bank_alarm_n_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////
    // clamp passes a two-stage sync, so three edges of it must be seen
    sequence clamp_held;
        supply_fault_clamp_in [*3];
    endsequence
    rope_onehot_a: assert property ($onehot0(rope_select_out))
        else $error("rope not one-hot");
    rope_gated_a: assert property (!$past(bank_select_strobe_in) |-> rope_select_out == 0)
        else $error("rope select outside strobe");
    clamp_off_a: assert property (clamp_held |=> rope_select_out == 0)
        else $error("rope select under clamp");
    set_gated_a: assert property (!$past(set_strobe_in) |-> set_line_out == 4'h0)
        else $error("set line outside strobe");
    set_onehot_a: assert property ($onehot0(set_line_out))
        else $error("set lines not one-hot");
    set_side_a: assert property (|set_line_out[3:2] |-> set_enable_out)
        else $error("set C or D without set enable");
    strand_onehot_a: assert property ($onehot0(strand_gate_out))
        else $error("strand not one-hot");
    alarm_merge_a: assert property (
        combined_bank_alarm_n_out == !(bank_alarm_one_out || bank_alarm_two_out))
        else $error("combined alarm mismatch");
    inhibit_copy_a: assert property (|inhibit_comp_out && !$past(manual_access_in)
        |-> inhibit_comp_out == $past(addr_in[6:0])) else $error("inhibit lines wrong");
    parity_cause_a: assert property (parity_inhibit_out && !$past(manual_access_in)
        |-> $past(addr_in[8]) && !(^$past(addr_in[8:0]))) else $error("parity inhibit wrong");
    parity_pair_a: assert property (parity_inhibit_out |-> !parity_inhibit_n_out)
        else $error("parity pair both high");
endmodule // fmsd_properties
bind fmsd_decoder fmsd_properties #(.ROPES(ROPES), .STRANDS(STRANDS), .INH_W(INH_W)) u_props (
    .mclk_in, .rst_in, .addr_in, .manual_access_in, .bank_select_strobe_in, .set_strobe_in,
    .supply_fault_clamp_in, .rope_select_out, .set_enable_out, .set_line_out, .strand_gate_out,
    .inhibit_comp_out, .parity_inhibit_out, .parity_inhibit_n_out, .bank_alarm_one_out,
    .bank_alarm_two_out, .combined_bank_alarm_n_out);
`default_nettype wire

// ---- dv/fmsd_rope_model.sv ----
/* rope memory stand-in: flags when the drive switches exactly one core.
   assumes active-high one-hot selects from the decoder. */
`timescale 1ns/1ps
`default_nettype none
module fmsd_rope_model (
    input  wire logic [5:0] rope_in,
    input  wire logic [3:0] set_in,
    input  wire logic [7:0] strand_in,
    output logic            core_hit_out
);
    // any double select would switch two cores, so it reads as no hit
    assign core_hit_out = $onehot(rope_in) && $onehot(set_in) && $onehot(strand_in);
endmodule // fmsd_rope_model
`default_nettype wire

// ---- dv/fmsd_decoder_tb.sv ----
/* self-checking bench for fmsd_decoder: bank sweeps, clamp, seeded random.
   assumes outputs answer one edge after the inputs are sampled. */
`timescale 1ns/1ps
`default_nettype none
module fmsd_decoder_tb;
    logic        mclk_in = 0, rst_in = 1, man = 0, bss = 0, sss = 0, iss = 0, clamp = 0;
    logic [4:0]  bank = 5'h00, fb;
    logic [11:0] addr = 12'h000;
    logic [14:0] pseudo = 15'h0000;
    logic [5:0]  rope;
    logic [3:0]  setl;
    logic [7:0]  strand;
    logic [6:0]  it, ic;
    logic        se, sea, seb, pi, pin, a1, a2, an, hit;
    logic [2:0]  clh = 3'h7;
    logic [45:0] ex;
    integer      failures = 0, samples_checked = 0, seed = 32'h28e7, i, r;
    always #10 mclk_in = ~mclk_in;
    fmsd_decoder u_dut (.mclk_in, .rst_in, .bank_number_register_in(bank), .addr_in(addr),
        .manual_access_in(man), .manual_pseudo_addr_in(pseudo), .bank_select_strobe_in(bss),
        .set_strobe_in(sss), .inhibit_strobe_in(iss), .supply_fault_clamp_in(clamp),
        .rope_select_out(rope), .set_enable_out(se), .strand_enable_a_out(sea),
        .strand_enable_b_out(seb), .set_line_out(setl), .strand_gate_out(strand),
        .inhibit_true_out(it), .inhibit_comp_out(ic), .parity_inhibit_out(pi),
        .parity_inhibit_n_out(pin), .bank_alarm_one_out(a1), .bank_alarm_two_out(a2),
        .combined_bank_alarm_n_out(an), .fixed_bank_out(fb));
    fmsd_rope_model u_rope (.rope_in(rope), .set_in(setl), .strand_in(strand), .core_hit_out(hit));
    ////////////////////////////////////////
    // expected outputs; c is the clamp as sampled two edges before the answer edge
    function automatic logic [45:0] expect_out(input logic m, input logic [4:0] rg,
        input logic [11:0] a, input logic [14:0] p, input logic b, s, n, c);
        logic [4:0] bk, o;
        logic [9:0] w;
        logic       v, fx, al1, al2, q, g;
        logic [5:0] rp;
        logic [3:0] sl;
        logic [7:0] sd;
        bk = m ? p[14:10] : a[11:10] == 2'h1 ? 5'h01 : a[11:10] == 2'h2 ? 5'h02 :
             rg < 5'h03 ? 5'h03 : rg;
        w = m ? p[9:0] : a[9:0];
        fx = m || a[11:10] != 2'h0;
        v = fx && ((bk >= 5'h01 && bk <= 5'h0c) || (bk >= 5'h11 && bk <= 5'h1c));
        al1 = fx && bk >= 5'h0d && bk <= 5'h10;
        al2 = fx && (bk == 5'h00 || bk >= 5'h1d);
        o = bk - (bk > 5'h0c ? 5'h05 : 5'h01);
        q = w[8] & ~^w[8:0];
        rp = (v && b && !c) ? 6'h01 << o[4:2] : 6'h00;
        sl = (v && s) ? 4'h1 << {bk[0], w[7]} : 4'h0;
        g = o[1] ^ o[0];
        sd = (v && b) ? 8'h01 << {g, w[9:8]} : 8'h00;
        return {rp, sl, sd, v ? bk : 5'h00, v & bk[0], v & ~g, v & g, al1, al2, ~(al1 | al2),
                (v && n) ? {~w[6:0], w[6:0]} : 14'h0000, v & n & q, v & n & ~q,
                |rp && |sl && |sd};
    endfunction
    task automatic check(input logic [45:0] seen, input logic [45:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one sample: inputs set at the falling edge, outputs read a cycle on
    task automatic cyc;
        clh = {clh[1:0], clamp};
        ex = expect_out(man, bank, addr, pseudo, bss, sss, iss, clh[2]);
        @(negedge mclk_in);
        check({rope, setl, strand, fb, se, sea, seb, a1, a2, an, it, ic, pi, pin, hit},
              ex);
    endtask
    task automatic summarize;
        $display("checked %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence: sweeps, clamp hold, then random traffic
    initial begin
        repeat (12) @(negedge mclk_in);
        rst_in = 0;
        for (i = 0; i < 96; i++) begin
            {bss, sss, iss} = {3{~i[6]}};
            bank = i[4:0];
            man = i[5];
            addr = 12'($random(seed)) | 12'hc00;
            pseudo = {i[4:0], 10'($random(seed))};
            cyc;
        end
        $display("bank and manual sweep done");
        // strobes on, so the clamp is the only thing holding the ropes off
        {man, clamp, bss, sss, iss, bank, addr} = {1'h0, 1'h1, 3'h7, 5'h05, 12'hc55};
        repeat (6) cyc;
        clamp = 0;
        repeat (4) cyc;
        $display("clamp test done");
        for (i = 0; i < 2000; i++) begin
            r = $random(seed);
            {bank, addr, bss, sss, iss, clamp} = r[20:0];
            man = r[31:29] == 3'h0;
            pseudo = 15'($random(seed));
            cyc;
        end
        $display("random test done");
        summarize;
    end
    // watchdog: about 2.4 times the expected run of some 42400 ns
    initial begin
        #100000;
        failures++;
        summarize;
    end
endmodule // fmsd_decoder_tb
`default_nettype wire
